// >>> common/gtm_pkg.sv
/*
 * shared constants and types of the general timer: register offsets,
 * control field positions, reset values and prescaler limits.
 * assumes a 32-bit axi4-lite slave with a 4-bit byte address.
 */
package gtm_pkg;

	// ==========================================================
	// bus geometry and answers
	localparam int unsigned GTM_AW = 4;
	localparam logic [1:0] GTM_RESP_OKAY = 2'b00;
	localparam logic [1:0] GTM_RESP_SLVERR = 2'b10;

	// ==========================================================
	// register byte offsets
	localparam logic [3:0] GTM_OFF_CTRL = 4'h0;
	localparam logic [3:0] GTM_OFF_PERIOD = 4'h4;
	localparam logic [3:0] GTM_OFF_COUNT = 4'h8;
	localparam logic [3:0] GTM_OFF_STATUS = 4'hc;

	// ==========================================================
	// timer_control field positions
	localparam int unsigned GTM_B_RUN = 15;
	localparam int unsigned GTM_B_IDLE = 13;
	localparam int unsigned GTM_B_GATE = 6;
	localparam int unsigned GTM_B_PS = 4;
	localparam int unsigned GTM_B_SYNC = 2;
	localparam int unsigned GTM_B_CS = 1;

	// status fields
	localparam int unsigned GTM_B_FLAG = 0;
	localparam int unsigned GTM_B_ACTIVE = 1;

	// ==========================================================
	// values after reset
	localparam logic [15:0] GTM_PERIOD_RST = 16'hffff;
	localparam logic [15:0] GTM_COUNT_RST = 16'h0000;

	// ==========================================================
	// prescale select codes and divider limits (ratio minus one)
	typedef enum logic [1:0] {
		GTM_PS_1 = 2'b00,
		GTM_PS_8 = 2'b01,
		GTM_PS_64 = 2'b10,
		GTM_PS_256 = 2'b11
	} gtm_ps_t;
	localparam logic [7:0] GTM_LIM_1 = 8'h00;
	localparam logic [7:0] GTM_LIM_8 = 8'h07;
	localparam logic [7:0] GTM_LIM_64 = 8'h3f;
	localparam logic [7:0] GTM_LIM_256 = 8'hff;

	// implemented control bits only; everything else reads zero
	typedef struct packed {
		logic timer_run;
		logic idle_halt;
		logic gated_accum_enable;
		gtm_ps_t prescale_select;
		logic ext_clock_synchronize;
		logic clock_source_select;
	} gtm_ctrl_t;
	localparam gtm_ctrl_t GTM_CTRL_RST = '{default: 1'b0, prescale_select: GTM_PS_1};

endpackage

// >>> hw/gtm_prescaler.sv
/*
 * prescaler of the general timer: divides a stream of input pulses
 * by 1, 8, 64 or 256 and emits one tick per full group.
 * assumes clr is held while the timer is stopped.
 */
`timescale 1ns/10ps
`default_nettype none

module gtm_prescaler
	import gtm_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// control
	input wire logic clr,
	input wire logic en,
	input wire gtm_ps_t sel,
	// result
	output logic tick
);

	typedef struct packed {
		logic [7:0] cnt;
	} gtm_ps_state_t;

	gtm_ps_state_t s, n;
	logic [7:0] lim;

	// ==========================================================
	// ratio decode
	// ratio select
	always_comb begin
		case (sel)
			GTM_PS_1: lim = GTM_LIM_1;
			GTM_PS_8: lim = GTM_LIM_8;
			GTM_PS_64: lim = GTM_LIM_64;
			GTM_PS_256: lim = GTM_LIM_256;
			default: lim = GTM_LIM_1;
		endcase
	end

	// tick on the last pulse of a group
	assign tick = en && !clr && (s.cnt >= lim);

	// next state: restart on clear, wrap at the limit
	always_comb begin
		n = s;
		if (clr) begin
			n.cnt = 8'h00;
		end else if (tick) begin
			n.cnt = 8'h00;
		end else if (en) begin
			n.cnt = s.cnt + 8'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_run8;
		(en && !clr && sel == GTM_PS_8)[*8];
	endsequence

	property p_div8;
		(tick && sel == GTM_PS_8) ##1 s_run8 |-> tick;
	endproperty
	a_div8: assert property (p_div8) else $error("1:8 prescale missed its eighth pulse");

	property p_div1;
		(en && !clr && sel == GTM_PS_1) |-> tick;
	endproperty
	a_div1: assert property (p_div1) else $error("1:1 prescale dropped a pulse");

endmodule // gtm_prescaler

`default_nettype wire

// >>> hw/gtm_pin_edge.sv
/*
 * external count pin front end: two-stage synchroniser plus rising edge
 * detection on either the synchronised or the raw sample; fall and level are synchronised only.
 * assumes the pin is sampled by clk only.
 */
`timescale 1ns/10ps
`default_nettype none

module gtm_pin_edge (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// pin and path choice
	input wire logic pin,
	input wire logic sync_sel,
	// results
	output logic rise,
	output logic fall,
	output logic level
);

	typedef struct packed {
		logic meta;
		logic sync;
		logic sync_prev;
		logic raw_prev;
	} gtm_pe_state_t;

	gtm_pe_state_t s, n;

	// ==========================================================
	// edges; the raw path trades metastability margin for latency
	// path select
	assign rise = sync_sel ? (s.sync && !s.sync_prev) : (pin && !s.raw_prev);
	assign fall = s.sync_prev && !s.sync;
	assign level = s.sync;

	// meta feeds only the second stage
	always_comb begin
		n = s;
		n.meta = pin;
		n.sync = s.meta;
		n.sync_prev = s.sync;
		n.raw_prev = pin;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_sync_rise;
		(sync_sel && rise) |-> ($past(pin, 2) && !$past(pin, 3));
	endproperty
	a_sync_rise: assert property (p_sync_rise) else $error("synchronised edge not two cycles late");

	property p_raw_rise;
		(!sync_sel && rise) |-> (pin && !$past(pin));
	endproperty
	a_raw_rise: assert property (p_raw_rise) else $error("raw edge not taken from the pin");

endmodule // gtm_pin_edge

`default_nettype wire

// >>> hw/gtm_timer.sv
/*
 * general 16-bit timer/counter with axi4-lite register access:
 * interval timer, synchronous and asynchronous external counter,
 * gated accumulation, prescaler, period match and event flag.
 * assumes idle_mode and sleep_mode come from the power controller,
 * and ext_count_pin is sampled by clk.
 */
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - a 16-bit count running as timer, sync counter or async counter
// - event raised on period match and on gate falling edge in gated mode
// - run bit 15 starts counting when 1, stops when 0
// - bit 13 set halts the timer in idle, clear keeps it counting
// - gated accumulation bit 6 acts only with the internal clock
// - prescale bits 5-4 divide by 1, 8, 64 or 256
// - with external clock, bit 2 picks synchronised or raw input
// - bit 1 picks external pin rising edge or internal clock
// - bits 14, 12-7, 3, 0 read zero and ignore writes
// - all control bits clear at reset: stopped, internal clock, 1:1
// - timer can keep running in idle, under the idle bit; in sleep only the raw external counter runs
module gtm_timer
	import gtm_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// axi4-lite write address
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [GTM_AW-1:0] s_axi_awaddr,
	// axi4-lite write data
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	// axi4-lite write response
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	// axi4-lite read address
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [GTM_AW-1:0] s_axi_araddr,
	// axi4-lite read data
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	// device power state
	input wire logic idle_mode,
	input wire logic sleep_mode,
	// external count or gate pin
	input wire logic ext_count_pin,
	// event to the interrupt controller
	output logic timer_irq_flag,
	output logic timer_irq_pulse
);

	typedef struct packed {
		logic aw_got;
		logic [GTM_AW-1:0] aw_addr;
		logic w_got;
		logic [15:0] wdata;
		logic [1:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [15:0] rdata;
		logic [1:0] rresp;
		gtm_ctrl_t ctrl;
		logic [15:0] period;
		logic [15:0] count;
		logic flag;
		logic irq_pulse;
	} gtm_state_t;

	gtm_state_t s, n;

	logic ext_rise;
	logic gate_fall;
	logic gate_level;
	logic gated;
	logic async_ext;
	logic hold;
	logic src_pulse;
	logic tick;
	logic wrap_evt;
	logic gate_evt;
	logic wr_go;
	logic cnt_wr;
	logic [15:0] ctrl_word;

	// ==========================================================
	// pin front end and prescaler
	gtm_pin_edge u_pin (
		.clk(clk),
		.rst(rst),
		.pin(ext_count_pin),
		.sync_sel(s.ctrl.ext_clock_synchronize),
		.rise(ext_rise),
		.fall(gate_fall),
		.level(gate_level)
	);

	gtm_prescaler u_ps (
		.clk(clk),
		.rst(rst),
		.clr(!s.ctrl.timer_run),
		.en(src_pulse && !hold),
		.sel(s.ctrl.prescale_select),
		.tick(tick)
	);

	// ==========================================================
	// source and halt decisions
	// gate only with internal clock
	assign gated = s.ctrl.gated_accum_enable && !s.ctrl.clock_source_select;
	assign async_ext = s.ctrl.clock_source_select && !s.ctrl.ext_clock_synchronize;

	assign src_pulse = s.ctrl.clock_source_select ? ext_rise : (gated ? gate_level : 1'b1);

	// only the raw external counter survives sleep
	assign hold = !s.ctrl.timer_run || (idle_mode && s.ctrl.idle_halt) || (sleep_mode && !async_ext);

	assign wrap_evt = tick && (s.count == s.period);
	assign gate_evt = gated && s.ctrl.timer_run && !hold && gate_fall;

	// bus write happens once both halves are held
	assign wr_go = s.aw_got && s.w_got && !s.bvalid;
	assign cnt_wr = wr_go && (s.aw_addr == GTM_OFF_COUNT) && (s.wstrb != 2'b00);

	always_comb begin
		ctrl_word = 16'h0000;
		ctrl_word[GTM_B_RUN] = s.ctrl.timer_run;
		ctrl_word[GTM_B_IDLE] = s.ctrl.idle_halt;
		ctrl_word[GTM_B_GATE] = s.ctrl.gated_accum_enable;
		ctrl_word[GTM_B_PS +: 2] = s.ctrl.prescale_select;
		ctrl_word[GTM_B_SYNC] = s.ctrl.ext_clock_synchronize;
		ctrl_word[GTM_B_CS] = s.ctrl.clock_source_select;
	end

	// ==========================================================
	// bus handshake outputs
	assign s_axi_awready = !s.aw_got && !s.bvalid;
	assign s_axi_wready = !s.w_got && !s.bvalid;
	assign s_axi_arready = !s.rvalid;
	assign s_axi_bvalid = s.bvalid;
	assign s_axi_bresp = s.bresp;
	assign s_axi_rvalid = s.rvalid;
	assign s_axi_rdata = {16'h0000, s.rdata};
	assign s_axi_rresp = s.rresp;
	assign timer_irq_flag = s.flag;
	assign timer_irq_pulse = s.irq_pulse;

	// byte-lane merge of a 16-bit register
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nw, input logic [1:0] st);
		merge16 = {st[1] ? nw[15:8] : old[15:8], st[0] ? nw[7:0] : old[7:0]};
	endfunction

	// ==========================================================
	// next state of the whole block
	always_comb begin
		n = s;
		n.irq_pulse = 1'b0;
		// capture write address and data in either order
		if (s_axi_awvalid && s_axi_awready) begin
			n.aw_got = 1'b1;
			n.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			n.w_got = 1'b1;
			n.wdata = s_axi_wdata[15:0];
			n.wstrb = s_axi_wstrb[1:0];
		end
		if (s.bvalid && s_axi_bready) begin
			n.bvalid = 1'b0;
		end
		// increment and wrap at the period
		// one 16-bit count serves every mode
		if (tick) begin
			if (wrap_evt) begin
				n.count = 16'h0000;
			end else begin
				n.count = s.count + 16'h0001;
			end
		end
		// register writes; a software count load beats the tick
		if (wr_go) begin
			n.aw_got = 1'b0;
			n.w_got = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = GTM_RESP_OKAY;
			case (s.aw_addr)
				GTM_OFF_CTRL: begin
					if (s.wstrb[1]) begin
						n.ctrl.timer_run = s.wdata[GTM_B_RUN];
						n.ctrl.idle_halt = s.wdata[GTM_B_IDLE];
					end
					if (s.wstrb[0]) begin
						n.ctrl.gated_accum_enable = s.wdata[GTM_B_GATE];
						n.ctrl.prescale_select = gtm_ps_t'(s.wdata[GTM_B_PS +: 2]);
						n.ctrl.ext_clock_synchronize = s.wdata[GTM_B_SYNC];
						n.ctrl.clock_source_select = s.wdata[GTM_B_CS];
					end
				end
				GTM_OFF_PERIOD: begin
					n.period = merge16(s.period, s.wdata, s.wstrb);
				end
				GTM_OFF_COUNT: begin
					n.count = merge16(s.count, s.wdata, s.wstrb);
				end
				GTM_OFF_STATUS: begin
					// write one to clear the flag
					if (s.wstrb[0] && s.wdata[GTM_B_FLAG]) begin
						n.flag = 1'b0;
					end
				end
				default: begin
					n.bresp = GTM_RESP_SLVERR;
				end
			endcase
		end
		// set wins over a clear in the same cycle
		if (wrap_evt || gate_evt) begin
			n.flag = 1'b1;
			n.irq_pulse = 1'b1;
		end
		// reads answer one cycle after the address is taken
		if (s.rvalid && s_axi_rready) begin
			n.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			n.rvalid = 1'b1;
			n.rresp = GTM_RESP_OKAY;
			case (s_axi_araddr)
				GTM_OFF_CTRL: n.rdata = ctrl_word;
				GTM_OFF_PERIOD: n.rdata = s.period;
				GTM_OFF_COUNT: n.rdata = s.count;
				GTM_OFF_STATUS: n.rdata = {14'h0000, !hold, s.flag};
				default: begin
					n.rdata = 16'h0000;
					n.rresp = GTM_RESP_SLVERR;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s <= '0;
			s.ctrl <= GTM_CTRL_RST;
			s.period <= GTM_PERIOD_RST;
			s.count <= GTM_COUNT_RST;
		end else begin
			s <= n;
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_wrap;
		(wrap_evt && !cnt_wr) |=> (s.count == 16'h0000) && s.flag && timer_irq_pulse;
	endproperty
	a_wrap: assert property (p_wrap) else $error("period match did not clear and flag");

	property p_inc;
		(tick && !wrap_evt && !cnt_wr) |=> (s.count == $past(s.count) + 16'h0001);
	endproperty
	a_inc: assert property (p_inc) else $error("tick did not advance the count");

	property p_stopped;
		(!s.ctrl.timer_run && !cnt_wr) |=> $stable(s.count);
	endproperty
	a_stopped: assert property (p_stopped) else $error("count moved while stopped");

	property p_idle;
		(idle_mode && s.ctrl.idle_halt && !cnt_wr) |=> $stable(s.count);
	endproperty
	a_idle: assert property (p_idle) else $error("count moved in idle with halt set");

	property p_ext_only;
		(s.ctrl.clock_source_select && !ext_rise) |-> !tick;
	endproperty
	a_ext_only: assert property (p_ext_only) else $error("external mode ticked without a pin edge");

	property p_gate_low;
		(gated && !gate_level) |-> !tick;
	endproperty
	a_gate_low: assert property (p_gate_low) else $error("gated count advanced with gate low");

	sequence s_gate_drop;
		gated && s.ctrl.timer_run && !hold ##0 gate_fall;
	endsequence

	property p_gate_evt;
		s_gate_drop |=> s.flag && timer_irq_pulse;
	endproperty
	a_gate_evt: assert property (p_gate_evt) else $error("gate falling edge raised no event");

	// a control read must come back with every unimplemented bit low
	property p_unimpl;
		(s_axi_arvalid && s_axi_arready && s_axi_araddr == GTM_OFF_CTRL)
			|=> s_axi_rvalid && ((s_axi_rdata & 32'hffff5f89) == 32'h00000000);
	endproperty
	a_unimpl: assert property (p_unimpl) else $error("unimplemented bits read nonzero");

	property p_reset;
		@(posedge clk) $fell(rst) |-> (ctrl_word == 16'h0000) && !s.flag && (s.count == 16'h0000);
	endproperty
	a_reset: assert property (p_reset) else $error("control not cleared by reset");

	property p_async_sleep;
		(sleep_mode && async_ext && s.ctrl.timer_run && !(idle_mode && s.ctrl.idle_halt)
			&& ext_rise && s.ctrl.prescale_select == GTM_PS_1) |-> tick;
	endproperty
	a_async_sleep: assert property (p_async_sleep) else $error("raw counter stalled in sleep");

	// sleep freezes every path that needs the instruction clock
	property p_sleep_hold;
		(sleep_mode && !async_ext) |-> !tick;
	endproperty
	a_sleep_hold: assert property (p_sleep_hold) else $error("synchronous path ticked in sleep");

	// a running 1:1 internal timer ticks on every clock
	property p_run_start;
		(s.ctrl.timer_run && !s.ctrl.clock_source_select && !s.ctrl.gated_accum_enable && !hold
			&& s.ctrl.prescale_select == GTM_PS_1) |-> tick;
	endproperty
	a_run_start: assert property (p_run_start) else $error("running 1:1 timer missed a tick");

endmodule // gtm_timer

`default_nettype wire

// >>> tb/gtm_pin_model.sv
/*
 * far-side model of the timer's external pin: a count clock source
 * or a gate source.
 * assumes the bench calls one task at a time, right after a clock edge.
 */
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// pin source
module gtm_pin_model (
	// clock
	input wire logic clk,
	// pin towards the timer
	output logic pin
);
	// the pin stands low between frames, like a stopped clock
	initial pin = 1'b0;

	// rising edges to count
	// h low then h high per pulse; h of 3 or more clears the synchroniser
	task automatic pulses(input int n, input int h);
		for (int i = 0; i < n; i++) begin
			repeat (h) @(posedge clk);
			pin <= 1'b1;
			repeat (h) @(posedge clk);
			pin <= 1'b0;
		end
	endtask

	task automatic gate(input int h);
		@(posedge clk);
		pin <= 1'b1;
		repeat (h) @(posedge clk);
		pin <= 1'b0;
	endtask
endmodule // gtm_pin_model

`default_nettype wire

// >>> tb/test_gtm_timer.sv
/*
 * self-checking bench of the general timer: registers over axi4-lite,
 * interval timing, prescale, idle, sleep, external and gated counting.
 * assumes the pin model drives the external pin and nothing else does.
 */
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// bench top
module test_gtm_timer;
	import gtm_pkg::*;

	logic clk = 1'b0;
	logic rst = 1'b1;
	logic awv = 1'b0, wv = 1'b0, brd = 1'b0, arv = 1'b0, rrd = 1'b0;
	logic idle_mode = 1'b0, sleep_mode = 1'b0;
	logic [3:0] awa = 4'h0, ara = 4'h0, wst = 4'h0;
	logic [31:0] wd = 32'h0;
	logic awr, wr_rdy, bv, arr, rv, flag, pulse, pin;
	logic [1:0] bresp, rresp, r;
	logic [31:0] rdata, v, x;
	int error_cnt = 0, n_checks = 0, m_per, m_cnt, t;
	int rat[4] = '{1, 8, 64, 256};
	logic [31:0] ext_code[$] = '{32'h8006, 32'h8002, 32'h8046, 32'h8016};
	int ext_exp[$] = '{16, 16, 16, 2};

	// 200 MHz clock
	always #2.5 clk = ~clk;

	gtm_timer uut (.clk(clk), .rst(rst),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
		.s_axi_wvalid(wv), .s_axi_wready(wr_rdy), .s_axi_wdata(wd), .s_axi_wstrb(wst),
		.s_axi_bvalid(bv), .s_axi_bready(brd), .s_axi_bresp(bresp),
		.s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
		.s_axi_rvalid(rv), .s_axi_rready(rrd), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.idle_mode(idle_mode), .sleep_mode(sleep_mode), .ext_count_pin(pin),
		.timer_irq_flag(flag), .timer_irq_pulse(pulse));

	gtm_pin_model pm (.clk(clk), .pin(pin));

	// ==========================================================
	// comparison and closing
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// ==========================================================
	// bus master: ready sampled just before the edge that takes the item
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		bit ah, wh, b;
		int k;
		k = 0;
		@(posedge clk);
		awv <= 1'b1;
		awa <= a;
		wv <= 1'b1;
		wd <= d;
		wst <= 4'hf;
		brd <= 1'b1;
		do begin
			@(negedge clk);
			ah = awv && awr;
			wh = wv && wr_rdy;
			b = bv;
			r = bresp;
			@(posedge clk);
			if (ah) awv <= 1'b0;
			if (wh) wv <= 1'b0;
			k++;
		end while (!b && k < 100);
		brd <= 1'b0;
		if (!b) chk("bvalid", 0, 1);
	endtask

	task automatic rd(input logic [3:0] a);
		bit ah, b;
		int k;
		k = 0;
		@(posedge clk);
		arv <= 1'b1;
		ara <= a;
		rrd <= 1'b1;
		do begin
			@(negedge clk);
			ah = arv && arr;
			b = rv;
			v = rdata;
			r = rresp;
			@(posedge clk);
			if (ah) arv <= 1'b0;
			k++;
		end while (!b && k < 100);
		rrd <= 1'b0;
		if (!b) chk("rvalid", 0, 1);
	endtask

	task automatic rdc(input logic [3:0] a, input logic [31:0] e, input string nm);
		rd(a);
		chk({nm, " rresp"}, r, GTM_RESP_OKAY);
		chk(nm, v, e);
	endtask

	// cycles until the next event pulse, bounded
	task automatic wait_pulse(output int c);
		c = 0;
		do begin
			@(negedge clk);
			c++;
		end while (pulse !== 1'b1 && c < 3000);
		if (c >= 3000) chk("pulse seen", 0, 1);
	endtask

	// ==========================================================
	// watchdog: the whole run needs well under 20000 cycles
	initial begin
		repeat (40000) @(posedge clk);
		error_cnt++;
		tally_and_finish;
	end

	// ==========================================================
	// main sequence
	initial begin
		void'($urandom(11089));
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		rdc(GTM_OFF_CTRL, 32'h0, "ctrl reset");
		rdc(GTM_OFF_PERIOD, {16'h0, GTM_PERIOD_RST}, "period reset");
		rdc(GTM_OFF_COUNT, 32'h0, "count reset");
		rd(4'h2);
		chk("unaligned rresp", r, GTM_RESP_SLVERR);
		wr(4'h6, 32'h1);
		chk("unaligned bresp", r, GTM_RESP_SLVERR);
		x = $urandom;
		wr(GTM_OFF_CTRL, x);
		chk("ctrl bresp", r, GTM_RESP_OKAY);
		rdc(GTM_OFF_CTRL, x & 32'h0000a076, "ctrl mask");
		$display("test registers done");
		// period match every (period+1)*ratio cycles; sync bit must not matter
		for (int ps = 0; ps < 4; ps++) begin
			m_per = $urandom_range(5, 2);
			wr(GTM_OFF_CTRL, 32'h0);
			wr(GTM_OFF_PERIOD, m_per);
			wr(GTM_OFF_COUNT, 32'h0);
			wr(GTM_OFF_CTRL, 32'h8000 | (ps << 4) | ((ps & 1) << 2));
			wait_pulse(t);
			wait_pulse(t);
			chk("interval", t, (m_per + 1) * rat[ps]);
			@(negedge clk);
			chk("pulse width", pulse, 1'b0);
			chk("flag", flag, 1'b1);
		end
		$display("test interval done");
		// stopped timer holds a loaded count; flag clears by write
		m_cnt = $urandom_range(16'h0fff, 16'h0100);
		wr(GTM_OFF_CTRL, 32'h0);
		wr(GTM_OFF_STATUS, 32'h1);
		rdc(GTM_OFF_STATUS, 32'h0, "status stopped");
		wr(GTM_OFF_COUNT, m_cnt);
		repeat (20) @(posedge clk);
		rdc(GTM_OFF_COUNT, m_cnt, "count held");
		// idle with halt bit set freezes, with it clear keeps running
		idle_mode <= 1'b1;
		wr(GTM_OFF_CTRL, 32'ha000);
		repeat (30) @(posedge clk);
		rdc(GTM_OFF_COUNT, m_cnt, "idle halted");
		wr(GTM_OFF_PERIOD, 32'h3);
		wr(GTM_OFF_COUNT, 32'h0);
		wr(GTM_OFF_CTRL, 32'h8000);
		wait_pulse(t);
		wait_pulse(t);
		chk("idle interval", t, 4);
		rdc(GTM_OFF_STATUS, 32'h3, "status active");
		idle_mode <= 1'b0;
		// sleep stops the internal clock path; flag stays set
		sleep_mode <= 1'b1;
		wr(GTM_OFF_COUNT, 32'h0);
		repeat (20) @(posedge clk);
		rdc(GTM_OFF_COUNT, 32'h0, "sleep halted");
		rdc(GTM_OFF_STATUS, 32'h1, "status halted");
		sleep_mode <= 1'b0;
		$display("test idle done");
		// external clock: sync, async in sleep, gate ignored, prescaled
		for (int i = 0; i < ext_code.size(); i++) begin
			wr(GTM_OFF_CTRL, 32'h0);
			wr(GTM_OFF_PERIOD, 32'hffff);
			wr(GTM_OFF_COUNT, 32'h0);
			sleep_mode <= (i == 1);
			wr(GTM_OFF_CTRL, ext_code[i]);
			pm.pulses(16, 4);
			repeat (8) @(posedge clk);
			wr(GTM_OFF_CTRL, 32'h0);
			rdc(GTM_OFF_COUNT, ext_exp[i], "ext count");
		end
		sleep_mode <= 1'b0;
		$display("test external done");
		// gated accumulation counts the gate width, fall raises the event
		wr(GTM_OFF_COUNT, 32'h0);
		wr(GTM_OFF_CTRL, 32'h8040);
		repeat (5) @(posedge clk);
		pm.gate(20);
		wait_pulse(t);
		chk("gate fall event", t < 10, 1'b1);
		wr(GTM_OFF_CTRL, 32'h0);
		rdc(GTM_OFF_COUNT, 32'd20, "gated count");
		$display("test gated done");
		tally_and_finish;
	end
endmodule // test_gtm_timer

`default_nettype wire
